// file: pkg/rtc_flags_pkg.sv
// Register map, field positions and timing constants of the alarm and flag block
`default_nettype none
package rtc_flags_pkg;
  // ==========================================
  // Register offsets
  localparam logic [4:0] off_seconds    = 5'h00;
  localparam logic [4:0] off_minutes    = 5'h01;
  localparam logic [4:0] off_hours      = 5'h02;
  localparam logic [4:0] off_day        = 5'h03;
  localparam logic [4:0] off_date       = 5'h04;
  localparam logic [4:0] off_month      = 5'h05;
  localparam logic [4:0] off_alarm_sec  = 5'h08;
  localparam logic [4:0] off_alarm_min  = 5'h09;
  localparam logic [4:0] off_alarm_hour = 5'h0a;
  localparam logic [4:0] off_alarm_dd   = 5'h0b;
  localparam logic [4:0] off_wdog_lo    = 5'h0c;
  localparam logic [4:0] off_wdog_hi    = 5'h0d;
  localparam logic [4:0] off_flags      = 5'h0e;
  localparam logic [4:0] off_ctrl       = 5'h0f;
  // ==========================================
  // Month byte fields
  localparam int bit_osc_disable_n       = 7;
  localparam int bit_clk32_out_disable_n = 6;
  localparam int bit_backup_clk32_enable = 5;
  // ==========================================
  // Alarm byte fields
  localparam int bit_alarm_mask   = 7;
  localparam int bit_alarm_day_sel = 6;
  // ==========================================
  // Flag byte fields
  localparam int bit_batt_low_main   = 7;
  localparam int bit_batt_low_aux    = 6;
  localparam int bit_power_fail_hold = 5;
  localparam int bit_power_release   = 4;
  localparam int bit_alarm_flag      = 3;
  localparam int bit_kick_flag       = 2;
  localparam int bit_wdog_flag       = 1;
  localparam int bit_irq_flag        = 0;
  // ==========================================
  // Control byte fields
  localparam int bit_transfer_en    = 7;
  localparam int bit_alarm_power_en = 4;
  localparam int bit_alarm_irq_en   = 3;
  localparam int bit_kick_irq_en    = 2;
  localparam int bit_wdog_en        = 1;
  localparam int bit_wdog_steer     = 0;
  // ==========================================
  // Reset values and timing
  localparam logic [7:0] ctrl_reset_mask  = 8'h0f;
  localparam logic [7:0] month_reset_mask = 8'h3f;
  localparam int         addr_stable_ns   = 15;
  localparam int         clock_period_ns  = 50;
  localparam int         addr_stable_cyc  =
    (addr_stable_ns + clock_period_ns - 1) / clock_period_ns;
endpackage
`default_nettype wire

// file: hw/alarm_match.sv
// Alarm mask decode and comparison against the time fields
`default_nettype none
module alarm_match (
  // Stored alarm bytes
  input  wire logic [7:0] alarm_sec,
  input  wire logic [7:0] alarm_min,
  input  wire logic [7:0] alarm_hour,
  input  wire logic [7:0] alarm_dd,
  // Current time fields
  input  wire logic [6:0] time_sec,
  input  wire logic [6:0] time_min,
  input  wire logic [5:0] time_hour,
  input  wire logic [2:0] time_day,
  input  wire logic [5:0] time_date,
  // Result
  output logic            match
);
  logic [3:0] mask;
  logic       m_sec;
  logic       m_min;
  logic       m_hour;
  logic       m_dd;
  logic [5:0] dd_ref;

  always_comb begin
    mask   = {alarm_dd[rtc_flags_pkg::bit_alarm_mask], alarm_hour[rtc_flags_pkg::bit_alarm_mask],
              alarm_min[rtc_flags_pkg::bit_alarm_mask], alarm_sec[rtc_flags_pkg::bit_alarm_mask]};
    // Day of week or date of month
    dd_ref = alarm_dd[rtc_flags_pkg::bit_alarm_day_sel] ? {3'h0, time_day} : time_date;
    m_sec  = (alarm_sec[6:0] == time_sec);
    m_min  = (alarm_min[6:0] == time_min);
    m_hour = (alarm_hour[5:0] == time_hour);
    m_dd   = (alarm_dd[5:0] == dd_ref);
    case (mask)
      4'hf:    match = 1'b1;
      4'he:    match = m_sec;
      4'hc:    match = m_sec & m_min;
      4'h8:    match = m_sec & m_min & m_hour;
      4'h0:    match = m_sec & m_min & m_hour & m_dd;
      default: match = 1'b1;
    endcase
  end
endmodule
`default_nettype wire

// file: hw/rtc_flags.sv
// Alarm, oscillator control and status flag logic of the byte-wide clock
//
// Contract
// - Power-up clears oscillator, output, enable bits
// - Mask bits select alarm match rate
// - Undefined mask patterns fire every second
// - Match sets alarm_flag
// - Day select picks date or weekday
// - osc_disable_n bit 7 stops oscillator
// - clk32_out_disable_n low routes clock out
// - backup_clk32_enable keeps clock in backup while aux_present
// - Battery-low bits are read-only status
// - power_fail_hold keeps power_on_n in fail
// - power_release low drives power_on_n
// - Alarm-power or kick clears power_release
// - alarm_power_en gates alarm wakeup
// - Flag read or zero-write clears flags
// - Kick event or write sets kick_flag
// - Watchdog timeout sets wdog_flag if period is nonzero
// - irq_flag is OR of enabled flags
// - irq_n low while irq_flag set
// - Read-clear after stable address, on release
// - Timeout sets wdog_flag regardless of enable
`default_nettype none
module rtc_flags (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       rst,
  // Byte-wide host bus
  input  wire logic       cs_n,
  input  wire logic       oe_n,
  input  wire logic       we_n,
  input  wire logic [4:0] addr,
  input  wire logic [7:0] wdata,
  output logic      [7:0] rdata,
  // Time keeping and watchdog events
  input  wire logic       sec_tick,
  input  wire logic       wdog_timeout,
  input  wire logic [6:0] time_sec,
  input  wire logic [6:0] time_min,
  input  wire logic [5:0] time_hour,
  input  wire logic [2:0] time_day,
  input  wire logic [5:0] time_date,
  // Supply status, kick input and oscillator clock pins
  input  wire logic       vbat_low,
  input  wire logic       vaux_low,
  input  wire logic       aux_present,
  input  wire logic       backup_mode,
  input  wire logic       power_fail,
  input  wire logic       kick_in_n,
  input  wire logic       osc_clk,
  // Outputs
  output logic            osc_run,
  output logic            square_out,
  output logic            irq_n_o,
  output logic            irq_n_oe,
  output logic            power_on_n_o,
  output logic            power_on_n_oe
);
  // ==========================================
  // Pin synchronisers
  // Address and data ride with the strobes so all settle together
  logic [18:0] sync1_q;
  logic [18:0] sync2_q;
  logic [18:0] pins;
  assign pins = {cs_n, oe_n, we_n, kick_in_n, vbat_low, vaux_low, addr, wdata};
  always_ff @(posedge clock) begin
    if (rst) begin
      sync1_q <= 19'h78000;
      sync2_q <= 19'h78000;
    end else begin
      sync1_q <= pins;
      sync2_q <= sync1_q;
    end
  end
  logic       cs_s, oe_s, we_s, kick_s, blm_s, bla_s;
  logic [4:0] addr_s;
  logic [7:0] wdata_s;
  assign {cs_s, oe_s, we_s, kick_s, blm_s, bla_s, addr_s, wdata_s} = sync2_q;

  // ==========================================
  // Registers
  logic [7:0] month_q, month_d;
  logic [7:0] asec_q, asec_d, amin_q, amin_d, ahour_q, ahour_d, add_q, add_d;
  logic [7:0] wlo_q, wlo_d, whi_q, whi_d, ctrl_q, ctrl_d;
  logic       hold_q, hold_d, rel_q, rel_d;
  logic       aflag_q, aflag_d, kflag_q, kflag_d, wflag_q, wflag_d;
  logic       we_prev_q, we_prev_d, kick_prev_q, kick_prev_d;
  logic [4:0] raddr_q, raddr_d;
  logic [1:0] stable_q, stable_d;
  logic       armed_q, armed_d;
  logic [7:0] rdata_q, rdata_d;

  logic       wr_stb, rd_act, rd_end, kick_evt, match, irq_flag;
  logic [7:0] flags_rd;

  alarm_match u_match (
    .alarm_sec  (asec_q),
    .alarm_min  (amin_q),
    .alarm_hour (ahour_q),
    .alarm_dd   (add_q),
    .time_sec   (time_sec),
    .time_min   (time_min),
    .time_hour  (time_hour),
    .time_day   (time_day),
    .time_date  (time_date),
    .match      (match)
  );

  // ==========================================
  // Bus decode and flag combination
  always_comb begin
    wr_stb   = !cs_s && !we_s && we_prev_q;
    rd_act   = !cs_s && !oe_s;
    kick_evt = !kick_s && kick_prev_q;
    irq_flag = (aflag_q & ctrl_q[rtc_flags_pkg::bit_alarm_irq_en]) |
               (kflag_q & ctrl_q[rtc_flags_pkg::bit_kick_irq_en]) |
               (wflag_q & ctrl_q[rtc_flags_pkg::bit_wdog_en]);
    flags_rd = {blm_s, bla_s, hold_q, rel_q, aflag_q, kflag_q, wflag_q, irq_flag};
    // Clear fires on release or address change once the address was stable
    rd_end   = armed_q && (!rd_act || addr_s != raddr_q);
  end

  // ==========================================
  // Next state
  always_comb begin
    month_d     = month_q;
    asec_d      = asec_q;
    amin_d      = amin_q;
    ahour_d     = ahour_q;
    add_d       = add_q;
    wlo_d       = wlo_q;
    whi_d       = whi_q;
    ctrl_d      = ctrl_q;
    hold_d      = hold_q;
    rel_d       = rel_q;
    aflag_d     = aflag_q;
    kflag_d     = kflag_q;
    wflag_d     = wflag_q;
    we_prev_d   = we_s;
    kick_prev_d = kick_s;
    raddr_d     = addr_s;
    rdata_d     = rdata_q;
    stable_d    = (rd_act && addr_s == raddr_q && stable_q != 2'h3) ? stable_q + 2'h1 :
                  (rd_act && addr_s == raddr_q) ? stable_q : 2'h0;
    armed_d     = rd_act && addr_s == raddr_q && addr_s == rtc_flags_pkg::off_flags &&
                  stable_q >= 2'(rtc_flags_pkg::addr_stable_cyc);
    if (rd_end) begin
      aflag_d = 1'b0;
      kflag_d = 1'b0;
      wflag_d = 1'b0;
    end
    if (rd_act) begin
      case (addr_s)
        rtc_flags_pkg::off_month:      rdata_d = month_q;
        rtc_flags_pkg::off_alarm_sec:  rdata_d = asec_q;
        rtc_flags_pkg::off_alarm_min:  rdata_d = amin_q;
        rtc_flags_pkg::off_alarm_hour: rdata_d = ahour_q;
        rtc_flags_pkg::off_alarm_dd:   rdata_d = add_q;
        rtc_flags_pkg::off_wdog_lo:    rdata_d = wlo_q;
        rtc_flags_pkg::off_wdog_hi:    rdata_d = whi_q;
        rtc_flags_pkg::off_flags:      rdata_d = flags_rd;
        rtc_flags_pkg::off_ctrl:       rdata_d = ctrl_q;
        default:                       rdata_d = 8'h00;
      endcase
    end
    if (wr_stb) begin
      case (addr_s)
        rtc_flags_pkg::off_month:      month_d = wdata_s;
        rtc_flags_pkg::off_alarm_sec:  asec_d  = wdata_s;
        rtc_flags_pkg::off_alarm_min:  amin_d  = wdata_s;
        rtc_flags_pkg::off_alarm_hour: ahour_d = wdata_s;
        rtc_flags_pkg::off_alarm_dd:   add_d   = wdata_s;
        rtc_flags_pkg::off_wdog_lo:    wlo_d   = wdata_s;
        rtc_flags_pkg::off_wdog_hi:    whi_d   = wdata_s;
        rtc_flags_pkg::off_ctrl:       ctrl_d  = wdata_s;
        rtc_flags_pkg::off_flags: begin
          hold_d  = wdata_s[rtc_flags_pkg::bit_power_fail_hold];
          rel_d   = wdata_s[rtc_flags_pkg::bit_power_release];
          if (!wdata_s[rtc_flags_pkg::bit_alarm_flag]) aflag_d = 1'b0;
          kflag_d = wdata_s[rtc_flags_pkg::bit_kick_flag];
          if (!wdata_s[rtc_flags_pkg::bit_wdog_flag]) wflag_d = 1'b0;
        end
        default: ;
      endcase
    end
    // Events win over any clear in the same cycle
    if (sec_tick && !month_q[rtc_flags_pkg::bit_osc_disable_n] && match)
      aflag_d = 1'b1;
    if (kick_evt)
      kflag_d = 1'b1;
    if (wdog_timeout && (wlo_q != 8'h00 || whi_q != 8'h00))
      wflag_d = 1'b1;
    if ((aflag_q && ctrl_q[rtc_flags_pkg::bit_alarm_power_en]) || kflag_q)
      rel_d = 1'b0;
  end

  // ==========================================
  // State registers
  always_ff @(posedge clock) begin
    if (rst) begin
      month_q <= 8'h00;
      ctrl_q  <= 8'h00;
      asec_q  <= 8'h00;
      amin_q  <= 8'h00;
      ahour_q <= 8'h00;
      add_q   <= 8'h00;
      wlo_q   <= 8'h00;
      whi_q   <= 8'h00;
      hold_q  <= 1'b0;
      rel_q   <= 1'b1;
      aflag_q <= 1'b0;
      kflag_q <= 1'b0;
      wflag_q <= 1'b0;
      we_prev_q   <= 1'b1;
      kick_prev_q <= 1'b1;
      raddr_q  <= 5'h00;
      stable_q <= 2'h0;
      armed_q  <= 1'b0;
      rdata_q  <= 8'h00;
    end else begin
      month_q <= month_d;
      ctrl_q  <= ctrl_d;
      asec_q  <= asec_d;
      amin_q  <= amin_d;
      ahour_q <= ahour_d;
      add_q   <= add_d;
      wlo_q   <= wlo_d;
      whi_q   <= whi_d;
      hold_q  <= hold_d;
      rel_q   <= rel_d;
      aflag_q <= aflag_d;
      kflag_q <= kflag_d;
      wflag_q <= wflag_d;
      we_prev_q   <= we_prev_d;
      kick_prev_q <= kick_prev_d;
      raddr_q  <= raddr_d;
      stable_q <= stable_d;
      armed_q  <= armed_d;
      rdata_q  <= rdata_d;
    end
  end

  // ==========================================
  // Outputs
  always_comb begin
    rdata    = rdata_q;
    osc_run  = !month_q[rtc_flags_pkg::bit_osc_disable_n];
    square_out = osc_run && osc_clk &&
      ((!backup_mode && !month_q[rtc_flags_pkg::bit_clk32_out_disable_n]) ||
       (backup_mode && aux_present && month_q[rtc_flags_pkg::bit_backup_clk32_enable]));
    irq_n_o  = 1'b0;
    irq_n_oe = irq_flag;
    power_on_n_o  = 1'b0;
    power_on_n_oe = !rel_q && (!power_fail || hold_q);
  end

  // ==========================================
  // Checks
  a_irq_pin_follows: assert property (@(posedge clock) disable iff (rst)
    irq_n_oe == ((aflag_q & ctrl_q[3]) | (kflag_q & ctrl_q[2]) | (wflag_q & ctrl_q[1])))
    else $error("irq pin does not follow enabled flags");
  a_alarm_sets_flag: assert property (@(posedge clock) disable iff (rst)
    (sec_tick && match && !month_q[7]) |=> aflag_q)
    else $error("alarm match did not set flag");
  a_kick_sets_flag: assert property (@(posedge clock) disable iff (rst)
    kick_evt |=> kflag_q)
    else $error("kick event did not set flag");
  a_release_cleared: assert property (@(posedge clock) disable iff (rst)
    kflag_q |=> !rel_q)
    else $error("kick flag did not clear power release");
  a_read_clear: assert property (@(posedge clock) disable iff (rst)
    (rd_end && !kick_evt) |=> !kflag_q)
    else $error("flag read did not clear kick flag");
  a_wdog_timeout: assert property (@(posedge clock) disable iff (rst)
    (wdog_timeout && wlo_q != 8'h00) |=> wflag_q)
    else $error("watchdog timeout did not set flag");
  a_power_drive: assert property (@(posedge clock) disable iff (rst)
    rel_q |-> !power_on_n_oe)
    else $error("power pin driven while released");
  a_osc_stop_quiet: assert property (@(posedge clock) disable iff (rst)
    month_q[7] |-> !square_out)
    else $error("clock output while oscillator stopped");
  a_reset_defaults: assert property (@(posedge clock)
    rst |=> (month_q[7:6] == 2'h0 && ctrl_q[3:0] == 4'h0))
    else $error("power-up control bits not cleared");
  a_wdog_no_period: assert property (@(posedge clock) disable iff (rst)
    (wdog_timeout && wlo_q == 8'h00 && whi_q == 8'h00 && !wflag_q) |=> !wflag_q)
    else $error("watchdog flag set with zero period");
  a_flag_write_zero: assert property (@(posedge clock) disable iff (rst)
    (wr_stb && addr_s == rtc_flags_pkg::off_flags &&
     !wdata_s[rtc_flags_pkg::bit_alarm_flag] &&
     !(sec_tick && match && !month_q[7])) |=> !aflag_q)
    else $error("zero write did not clear alarm flag");
  a_square_backup: assert property (@(posedge clock) disable iff (rst)
    (backup_mode && !aux_present) |-> !square_out)
    else $error("backup clock output without auxiliary supply");
  a_power_fail_float: assert property (@(posedge clock) disable iff (rst)
    (power_fail && !hold_q) |-> !power_on_n_oe)
    else $error("power pin driven in power-fail without hold");
  a_release_alarm: assert property (@(posedge clock) disable iff (rst)
    (aflag_q && ctrl_q[4]) |=> !rel_q)
    else $error("alarm wakeup did not clear power release");
endmodule
`default_nettype wire

// file: test/host_model.sv
// Host processor model driving the byte-wide strobe bus
`default_nettype none
module host_model (
  // Clock
  input  wire logic       clock,
  // Byte-wide bus
  output logic            cs_n,
  output logic            oe_n,
  output logic            we_n,
  output logic      [4:0] addr,
  output logic      [7:0] wdata,
  input  wire logic [7:0] rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    cs_n  = 1'b1;
    oe_n  = 1'b1;
    we_n  = 1'b1;
    addr  = 5'h1f;
    wdata = 8'h00;
  end
  // ==========================================
  // Write: strobe covers the pin synchroniser, data inverted once released
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clock);
    addr  <= a;
    wdata <= d;
    cs_n  <= 1'b0;
    we_n  <= 1'b0;
    repeat (4) @(posedge clock);
    cs_n  <= 1'b1;
    we_n  <= 1'b1;
    wdata <= ~d;
    repeat (4) @(posedge clock);
  endtask
  // ==========================================
  // Read: address held stable through the strobe arms the clear, release fires it
  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    @(posedge clock);
    addr <= a;
    cs_n <= 1'b0;
    oe_n <= 1'b0;
    repeat (6) @(posedge clock);
    d = rdata;
    cs_n <= 1'b1;
    oe_n <= 1'b1;
    repeat (5) @(posedge clock);
  endtask
endmodule
`default_nettype wire

// file: test/rtc_flags_tb_top.sv
// Self-checking bench for the alarm and status flag block
`default_nettype none
module rtc_flags_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clock = 1'b0;
  logic       rst = 1'b1;
  logic       cs_n, oe_n, we_n;
  logic [4:0] addr;
  logic [7:0] wdata, rdata, v;
  logic       sec_tick = 1'b0, wdog_timeout = 1'b0;
  logic [6:0] time_sec = 7'h00, time_min = 7'h00;
  logic [5:0] time_hour = 6'h00, time_date = 6'h00;
  logic [2:0] time_day = 3'h0;
  logic       vbat_low = 1'b0, vaux_low = 1'b0, aux_present = 1'b0;
  logic       backup_mode = 1'b0, power_fail = 1'b0, kick_in_n = 1'b1;
  logic       osc_clk = 1'b0;
  logic       osc_run, square_out, irq_n_o, irq_n_oe, power_on_n_o, power_on_n_oe;
  logic [8:0] e;
  int         fails = 0;
  int         check_count = 0;
  // Alarm cases: mask AM4..AM1, day select, mismatched field, expected fire
  logic [8:0] tbl [13] = '{9'h1e3, 9'h1c2, 9'h1c5, 9'h184, 9'h187, 9'h106, 9'h109,
                           9'h008, 9'h00b, 9'h01a, 9'h019, 9'h143, 9'h0a7};
  always #25 clock = ~clock;
  host_model host (.clock(clock), .cs_n(cs_n), .oe_n(oe_n), .we_n(we_n), .addr(addr),
                   .wdata(wdata), .rdata(rdata));
  rtc_flags uut (.clock(clock), .rst(rst), .cs_n(cs_n), .oe_n(oe_n), .we_n(we_n),
    .addr(addr), .wdata(wdata), .rdata(rdata), .sec_tick(sec_tick),
    .wdog_timeout(wdog_timeout), .time_sec(time_sec), .time_min(time_min),
    .time_hour(time_hour), .time_day(time_day), .time_date(time_date),
    .vbat_low(vbat_low), .vaux_low(vaux_low), .aux_present(aux_present),
    .backup_mode(backup_mode), .power_fail(power_fail), .kick_in_n(kick_in_n),
    .osc_clk(osc_clk), .osc_run(osc_run), .square_out(square_out), .irq_n_o(irq_n_o),
    .irq_n_oe(irq_n_oe), .power_on_n_o(power_on_n_o), .power_on_n_oe(power_on_n_oe));
  // ==========================================
  // Helpers
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("fails=%0d check_count=%0d", fails, check_count);
    if (fails == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic rf();
    host.rd(rtc_flags_pkg::off_flags, v);
  endtask
  task automatic wf(input logic [7:0] d);
    host.wr(rtc_flags_pkg::off_flags, d);
  endtask
  task automatic wc(input logic [7:0] d);
    host.wr(rtc_flags_pkg::off_ctrl, d);
  endtask
  task automatic wm(input logic [7:0] d);
    host.wr(rtc_flags_pkg::off_month, d);
  endtask
  task automatic tick();
    @(posedge clock);
    sec_tick <= 1'b1;
    @(posedge clock);
    sec_tick <= 1'b0;
    cyc(3);
  endtask
  task automatic wd();
    @(posedge clock);
    wdog_timeout <= 1'b1;
    @(posedge clock);
    wdog_timeout <= 1'b0;
    cyc(3);
  endtask
  initial begin
    cyc(20000);
    fails++;
    report_and_stop();
  end
  // ==========================================
  // Main sequence
  initial begin
    cyc(16);
    rst <= 1'b0;
    cyc(4);
    host.rd(rtc_flags_pkg::off_month, v);
    chk(v & 8'hc0, 8'h00);
    host.rd(rtc_flags_pkg::off_ctrl, v);
    chk(v & 8'h0f, 8'h00);
    chk({7'h0, osc_run}, 8'h01);
    vbat_low <= 1'b1;
    wf(8'hd0);
    rf();
    chk(v, 8'h90);
    vbat_low <= 1'b0;
    vaux_low <= 1'b1;
    rf();
    chk(v, 8'h50);
    vaux_low <= 1'b0;
    wc(8'h88);
    for (int i = 0; i < 13; i++) begin
      e = tbl[i];
      host.wr(rtc_flags_pkg::off_alarm_sec, {e[5], 7'h30});
      host.wr(rtc_flags_pkg::off_alarm_min, {e[6], 7'h15});
      host.wr(rtc_flags_pkg::off_alarm_hour, {e[7], 7'h12});
      host.wr(rtc_flags_pkg::off_alarm_dd, {e[8], e[4], 6'h05});
      time_sec <= 7'h30 ^ {6'h0, e[3:1] == 3'd1};
      time_min <= 7'h15 ^ {6'h0, e[3:1] == 3'd2};
      time_hour <= 6'h12 ^ {5'h0, e[3:1] == 3'd3};
      time_date <= 6'h05 ^ {5'h0, e[3:1] == 3'd4};
      time_day <= 3'd5 ^ {2'h0, e[3:1] == 3'd5};
      tick();
      chk({7'h0, irq_n_oe}, {7'h0, e[0]});
      chk({7'h0, power_on_n_oe}, 8'h00);
      rf();
      chk(v & 8'h09, {4'h0, e[0], 2'h0, e[0]});
      rf();
      chk(v & 8'h09, 8'h00);
    end
    wf(8'h00);
    chk({7'h0, power_on_n_oe}, 8'h01);
    power_fail <= 1'b1;
    cyc(2);
    chk({7'h0, power_on_n_oe}, 8'h00);
    wf(8'h20);
    chk({7'h0, power_on_n_oe}, 8'h01);
    power_fail <= 1'b0;
    wf(8'h10);
    chk({7'h0, power_on_n_oe}, 8'h00);
    wc(8'h98);
    tick();
    chk({7'h0, power_on_n_oe}, 8'h01);
    rf();
    chk(v & 8'h1f, 8'h09);
    wf(8'h10);
    wc(8'h80);
    kick_in_n <= 1'b0;
    cyc(4);
    kick_in_n <= 1'b1;
    cyc(4);
    chk({7'h0, power_on_n_oe}, 8'h01);
    chk({7'h0, irq_n_oe}, 8'h00);
    rf();
    chk(v & 8'h17, 8'h04);
    wc(8'h84);
    wf(8'h14);
    chk({7'h0, irq_n_oe}, 8'h01);
    chk({6'h0, irq_n_o, power_on_n_o}, 8'h00);
    wf(8'h10);
    chk({7'h0, irq_n_oe}, 8'h00);
    wd();
    rf();
    chk(v & 8'h03, 8'h00);
    host.wr(rtc_flags_pkg::off_wdog_lo, 8'h01);
    wd();
    rf();
    chk(v & 8'h03, 8'h02);
    wd();
    wc(8'h82);
    chk({7'h0, irq_n_oe}, 8'h01);
    wf(8'h10);
    chk({7'h0, irq_n_oe}, 8'h00);
    osc_clk <= 1'b1;
    cyc(2);
    chk({7'h0, square_out}, 8'h01);
    wm(8'h40);
    chk({7'h0, square_out}, 8'h00);
    wm(8'h80);
    chk({6'h0, osc_run, square_out}, 8'h00);
    host.rd(rtc_flags_pkg::off_month, v);
    chk(v & 8'he0, 8'h80);
    backup_mode <= 1'b1;
    aux_present <= 1'b1;
    wm(8'h20);
    chk({7'h0, square_out}, 8'h01);
    aux_present <= 1'b0;
    cyc(2);
    chk({7'h0, square_out}, 8'h00);
    report_and_stop();
  end
endmodule
`default_nettype wire
